// ==== verilog/lszm_top.sv ====
// Result stage: hold, compare, zero shift, teach and monitor output
//
// Contract
// - Input word shows value or compare flags
// - Extreme top flag when value >= setpoint
// - Top flag when value >= setpoint
// - Bottom flag when value <= setpoint
// - Deep bottom flag when value <= setpoint
// - In-band flag when no limit flag
// - Normal hold: hysteresis before clearing flags
// - Teach accepted only in normal hold
// - Scaling teach captures raw input point
// - Set teach captures measured value as setpoint
// - Null request shifts value to zero
// - Zero shift stays until null cancel
// - Zero lamp lit while shift active
// - Null request ignored in peak-to-peak hold
// - Monitor output refreshed every half second when direct or a result is in force
// - Monitor source: scaled value or direct word
// - Direct codes map to plus/minus 9.999 V
// - Out-of-range direct codes saturate
// - Output words C000-CFFF are commands
// - Gate: edge, level or ignored per hold
// - Hold release leaves held state
// - Open lamp only on unipolar input types
// - Overrange or open flag in input word
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module lszm_top
    import lszm_pkg::*;
#(
    parameter int MON_CYC = MON_PERIOD_CYC    // Monitor refresh period
) (
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire lszm_pkg::lszm_apb_req_t APB_REQ,
    output logic [31:0]               PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic signed [15:0]   SCALED_VALUE,
    input  wire logic [15:0]          RAW_VALUE,
    input  wire logic                 OVERRANGE,
    input  wire logic                 OPEN_DETECT,
    input  wire logic                 SAMPLE_GATE_INPUT,
    input  wire logic                 HOLD_RELEASE_INPUT,
    input  wire logic                 NULL_REQUEST_INPUT,
    input  wire logic                 NULL_CANCEL_INPUT,
    output logic signed [15:0]        MON_CODE,
    output logic                      ZERO_LAMP,
    output logic                      OPEN_INPUT_LAMP,
    output logic                      GATE_LAMP
);
    import lszm_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bit order: gate, release, null request, null cancel
    logic [3:0] pin_raw;                 // Raw pins
    logic [3:0] s1_reg, s2_reg, s3_reg;  // Three-stage chain
    logic [3:0] pin_reg, pin_next;       // Filtered levels
    logic [3:0] pin_d_reg;               // Previous filtered level
    logic [3:0] agree;                   // Stage 2 and 3 match

    assign pin_raw  = {SAMPLE_GATE_INPUT, HOLD_RELEASE_INPUT,
                       NULL_REQUEST_INPUT, NULL_CANCEL_INPUT};
    assign agree    = ~(s2_reg ^ s3_reg);
    // A change only counts once two late stages agree
    assign pin_next = (s2_reg & agree) | (pin_reg & ~agree);

    // Chain and filter
    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_reg    <= 4'h0;
            s2_reg    <= 4'h0;
            s3_reg    <= 4'h0;
            pin_reg   <= 4'h0;
            pin_d_reg <= 4'h0;
        end else begin
            s1_reg    <= pin_raw;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            pin_reg   <= pin_next;
            pin_d_reg <= pin_reg;
        end
    end

    wire gate      = pin_reg[3];
    wire gate_rise = pin_reg[3] & ~pin_d_reg[3];
    wire gate_fall = ~pin_reg[3] & pin_d_reg[3];
    wire release_l = pin_reg[2];
    wire null_rise = pin_reg[1] & ~pin_d_reg[1];
    wire cancel    = pin_reg[0];

    // ------------------------------------------------------------
    // Registers and APB decode
    // ------------------------------------------------------------
    logic [6:0]         ctrl_reg;                 // Mode control
    logic [15:0]        hyst_reg;                 // Hysteresis width
    logic signed [15:0] sp_xt_reg, sp_t_reg;      // Upper setpoints
    logic signed [15:0] sp_b_reg, sp_db_reg;      // Lower setpoints
    logic [15:0]        x1_reg, x2_reg;           // Scaling points
    logic [15:0]        dac_reg;                  // Direct output data
    logic               cmd_err_reg;              // Last command refused
    logic [31:0]        prdata_reg;               // Read data latch

    wire        setup   = APB_REQ.psel & ~APB_REQ.penable;
    wire        access  = APB_REQ.psel & APB_REQ.penable;
    wire        wr      = access & APB_REQ.pwrite;
    wire [7:0]  addr    = APB_REQ.paddr;
    wire [15:0] wdat    = APB_REQ.pwdata[15:0];
    wire        mode_cmp = ctrl_reg[CTRL_MODE_BIT];
    wire [2:0]  hold    = ctrl_reg[CTRL_HOLD_LSB +: 3];
    wire        mon_dir = ctrl_reg[CTRL_MON_BIT];
    wire [1:0]  in_type = ctrl_reg[CTRL_TYPE_LSB +: 2];
    wire        normal  = (hold == HOLD_NORMAL);
    wire        mapped  = (addr[1:0] == 2'b00) && (addr <= OFF_ZOFS);

    // Output word writes split into commands and direct data
    wire wr_out  = wr & (addr == OFF_OUTWORD);
    wire is_cmd  = (wdat[15:12] == CMD_NIB);
    wire cmd_scl = wr_out & is_cmd & (wdat[11:8] == CMD_SCL_TEACH);
    wire cmd_set = wr_out & is_cmd & (wdat[11:8] == CMD_SET_TEACH);
    wire teach   = (cmd_scl | cmd_set) & normal;
    wire refuse  = (cmd_scl | cmd_set) & ~normal;

    assign PREADY  = 1'b1;                       // Always one access cycle
    assign PSLVERR = access & ~mapped;
    assign PRDATA  = prdata_reg;

    // ------------------------------------------------------------
    // Zero shift
    // ------------------------------------------------------------
    logic               zero_reg;                // Shift active
    logic signed [15:0] zofs_reg;                // Offset captured
    wire  zero_req = null_rise & (hold != HOLD_P2P);

    // Capture on request, drop on cancel; a request edge wins the tie
    always_ff @(posedge CLK) begin
        if (RST) begin
            zero_reg <= 1'b0;
            zofs_reg <= ZERO_RST;
        end else if (zero_req) begin
            zero_reg <= 1'b1;
            zofs_reg <= SCALED_VALUE;
        end else if (cancel) begin
            zero_reg <= 1'b0;
            zofs_reg <= ZERO_RST;
        end
    end
    assign ZERO_LAMP = zero_reg;

    // Shifted value, kept wide then clamped
    wire signed [17:0] shift_w = 18'(SCALED_VALUE) -
                                 (zero_reg ? 18'(zofs_reg) : 18'sh0);
    wire signed [15:0] val     = lszm_clamp(shift_w);
    wire               val_ov  = (shift_w != 18'(val));

    // ------------------------------------------------------------
    // Hold sequencer
    // ------------------------------------------------------------
    lszm_hold_t         hs_reg, hs_next;         // Hold state
    logic signed [15:0] held_reg, held_next;     // Held result
    logic signed [15:0] max_reg, min_reg;        // Running extremes
    logic               load;                    // New held result
    wire signed [17:0]  p2p_w = 18'(max_reg) - 18'(min_reg);

    // Next state; release beats the gate
    always_comb begin
        hs_next   = hs_reg;
        held_next = held_reg;
        load      = 1'b0;
        case (hs_reg)
            HS_EMPTY, HS_HELD: begin
                if (release_l) begin
                    hs_next = HS_EMPTY;
                end else if (gate_rise && hold == HOLD_SAMPLE) begin
                    hs_next   = HS_HELD;
                    held_next = val;
                    load      = 1'b1;
                end else if (gate_rise && hold != HOLD_SAMPLE) begin
                    hs_next = HS_GATHER;
                end
            end
            HS_GATHER: begin
                if (release_l) begin
                    hs_next = HS_EMPTY;
                end else if (gate_fall) begin
                    hs_next = HS_HELD;
                    load    = 1'b1;
                    case (hold)
                        HOLD_MAX: held_next = max_reg;
                        HOLD_MIN: held_next = min_reg;
                        default:  held_next = lszm_clamp(p2p_w);
                    endcase
                end
            end
            default: hs_next = HS_EMPTY;
        endcase
    end

    // State, held value and extremes
    always_ff @(posedge CLK) begin
        if (RST || normal) begin
            hs_reg   <= HS_EMPTY;
            held_reg <= 16'sh0000;
            max_reg  <= 16'sh0000;
            min_reg  <= 16'sh0000;
        end else begin
            hs_reg   <= hs_next;
            held_reg <= held_next;
            if (gate_rise) begin
                max_reg <= val;
                min_reg <= val;
            end else if (hs_reg == HS_GATHER && gate) begin
                max_reg <= (val > max_reg) ? val : max_reg;
                min_reg <= (val < min_reg) ? val : min_reg;
            end
        end
    end

    // Result in force: live in normal hold, else last held value
    wire signed [15:0] res    = normal ? val : held_reg;
    wire               res_ok = normal | (hs_reg == HS_HELD);
    wire               upd    = normal | load;
    wire signed [15:0] cmp_v  = normal ? val : held_next;

    // ------------------------------------------------------------
    // Comparison with hysteresis
    // ------------------------------------------------------------
    logic xt_reg, t_reg, b_reg, db_reg;          // Limit flags
    wire signed [17:0] v_w   = 18'(cmp_v);
    wire signed [17:0] hy_w  = {2'b00, hyst_reg};
    wire use_hy = normal;
    wire xt_set = (cmp_v >= sp_xt_reg);
    wire t_set  = (cmp_v >= sp_t_reg);
    wire b_set  = (cmp_v <= sp_b_reg);
    wire db_set = (cmp_v <= sp_db_reg);
    wire xt_hold = use_hy & xt_reg & (v_w >= 18'(sp_xt_reg) - hy_w);
    wire t_hold  = use_hy & t_reg  & (v_w >= 18'(sp_t_reg) - hy_w);
    wire b_hold  = use_hy & b_reg  & (v_w <= 18'(sp_b_reg) + hy_w);
    wire db_hold = use_hy & db_reg & (v_w <= 18'(sp_db_reg) + hy_w);

    // Flags clear while nothing is held, else move only with a live or newly held result
    always_ff @(posedge CLK) begin
        if (RST) begin
            xt_reg <= 1'b0;
            t_reg  <= 1'b0;
            b_reg  <= 1'b0;
            db_reg <= 1'b0;
        end else if (!normal && hs_reg == HS_EMPTY && !load) begin
            xt_reg <= 1'b0;                      // Nothing held
            t_reg  <= 1'b0;
            b_reg  <= 1'b0;
            db_reg <= 1'b0;
        end else if (upd) begin
            xt_reg <= xt_set | xt_hold;
            t_reg  <= t_set | t_hold;
            b_reg  <= b_set | b_hold;
            db_reg <= db_set | db_hold;
        end
    end

    // Fault flag and lamps
    wire unipolar = (in_type >= TYPE_1TO5V);
    wire fault    = OVERRANGE | val_ov | (OPEN_DETECT & unipolar);
    assign OPEN_INPUT_LAMP = OPEN_DETECT & unipolar;
    assign GATE_LAMP       = gate;

    wire in_band = ~(xt_reg | t_reg | b_reg | db_reg);
    wire [15:0] flags = 16'(({fault, xt_reg, t_reg, in_band,
                              b_reg, db_reg}));
    // Input word by data mode
    wire [15:0] in_word = mode_cmp ? flags :
                          (res_ok ? res : WORD_INVALID);

    // ------------------------------------------------------------
    // Registers written by software or by teaching
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_reg    <= CTRL_RST;
            hyst_reg    <= HYST_RST;
            sp_xt_reg   <= VAL_MAX;
            sp_t_reg    <= VAL_MAX;
            sp_b_reg    <= VAL_MIN;
            sp_db_reg   <= VAL_MIN;
            x1_reg      <= 16'h0000;
            x2_reg      <= 16'h0000;
            dac_reg     <= 16'h0000;
            cmd_err_reg <= 1'b0;
        end else begin
            if (wr && addr == OFF_CTRL)
                ctrl_reg <= APB_REQ.pwdata[6:0];
            if (wr && addr == OFF_HYST)
                hyst_reg <= wdat;
            if (wr && addr == OFF_SP_XT)
                sp_xt_reg <= wdat;
            if (wr && addr == OFF_SP_T)
                sp_t_reg <= wdat;
            if (wr && addr == OFF_SP_B)
                sp_b_reg <= wdat;
            if (wr && addr == OFF_SP_DB)
                sp_db_reg <= wdat;
            if (wr && addr == OFF_X1)
                x1_reg <= wdat;
            if (wr && addr == OFF_X2)
                x2_reg <= wdat;
            // Command range never reaches the direct output
            if (wr_out && !is_cmd)
                dac_reg <= wdat;
            if (cmd_scl || cmd_set)
                cmd_err_reg <= refuse;
            if (teach && cmd_scl) begin
                if (wdat[4])
                    x2_reg <= RAW_VALUE;
                else
                    x1_reg <= RAW_VALUE;
            end
            if (teach && cmd_set) begin
                case (wdat[5:4])
                    2'd0:    sp_xt_reg <= val;
                    2'd1:    sp_t_reg  <= val;
                    2'd2:    sp_b_reg  <= val;
                    default: sp_db_reg <= val;
                endcase
            end
        end
    end

    // Read mux, latched in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        case (addr)
            OFF_CTRL:    rd_mux = 32'(ctrl_reg);
            OFF_OUTWORD: rd_mux = 32'(dac_reg);
            OFF_INWORD:  rd_mux = 32'(in_word);
            OFF_STATUS:  rd_mux = 32'({hs_reg, fault, zero_reg,
                                       cmd_err_reg});
            OFF_HYST:    rd_mux = 32'(hyst_reg);
            OFF_SP_XT:   rd_mux = 32'(sp_xt_reg);
            OFF_SP_T:    rd_mux = 32'(sp_t_reg);
            OFF_SP_B:    rd_mux = 32'(sp_b_reg);
            OFF_SP_DB:   rd_mux = 32'(sp_db_reg);
            OFF_X1:      rd_mux = 32'(x1_reg);
            OFF_X2:      rd_mux = 32'(x2_reg);
            OFF_ZOFS:    rd_mux = 32'(zofs_reg);
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // Upper read bits zero, values kept unsigned in the word
    always_ff @(posedge CLK) begin
        if (RST)
            prdata_reg <= 32'h0000_0000;
        else if (setup)
            prdata_reg <= {16'h0000, rd_mux[15:0]};
    end

    // ------------------------------------------------------------
    // Monitor output
    // ------------------------------------------------------------
    // One count is one millivolt; range +-9999 is +-9.999 V
    logic [31:0]        mon_cnt_reg;             // Refresh divider
    logic signed [15:0] mon_reg;                 // Code on the output
    wire mon_tick = (mon_cnt_reg == 32'(MON_CYC - 1));
    wire signed [15:0] dac_sat = lszm_clamp(18'($signed(dac_reg)));
    wire signed [15:0] mon_src = mon_dir ? dac_sat : res;

    // Refresh only on the half-second tick
    always_ff @(posedge CLK) begin
        if (RST) begin
            mon_cnt_reg <= 32'h0000_0000;
            mon_reg     <= 16'sh0000;
        end else begin
            mon_cnt_reg <= mon_tick ? 32'h0000_0000 : mon_cnt_reg + 1;
            if (mon_tick && (mon_dir || res_ok))
                mon_reg <= mon_src;
        end
    end
    assign MON_CODE = mon_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_in_band: assert property (@(posedge CLK) disable iff (RST)
        in_band == !(xt_reg || t_reg || b_reg || db_reg))
        else $error("in-band flag disagrees with limit flags");

    chk_top_set: assert property (@(posedge CLK) disable iff (RST)
        upd && t_set |=> t_reg)
        else $error("top flag not set at setpoint");

    chk_xtop_set: assert property (@(posedge CLK) disable iff (RST)
        upd && xt_set |=> xt_reg)
        else $error("extreme top flag not set");

    chk_bottom_set: assert property (@(posedge CLK) disable iff (RST)
        upd && b_set && db_set |=> b_reg && db_reg)
        else $error("bottom flags not set");

    chk_zero_cancel: assert property (@(posedge CLK) disable iff (RST)
        cancel && !zero_req |=> !ZERO_LAMP && zofs_reg == 16'sh0000)
        else $error("zero shift survived cancel");

    chk_p2p_nozero: assert property (@(posedge CLK) disable iff (RST)
        hold == HOLD_P2P && !zero_reg |=> !zero_reg)
        else $error("zero shift taken in peak hold");

    chk_teach_block: assert property (@(posedge CLK) disable iff (RST)
        refuse |=> cmd_err_reg && $stable(sp_xt_reg)
                   && $stable(x1_reg))
        else $error("teach taken outside normal hold");

    chk_cmd_not_data: assert property (@(posedge CLK) disable iff (RST)
        wr_out && is_cmd |=> $stable(dac_reg))
        else $error("command word reached direct output");

    chk_mon_still: assert property (@(posedge CLK) disable iff (RST)
        !mon_tick |=> $stable(MON_CODE))
        else $error("monitor changed between refreshes");

    chk_dac_sat: assert property (@(posedge CLK) disable iff (RST)
        mon_tick && mon_dir && $signed(dac_reg) > VAL_MAX
        |=> MON_CODE == VAL_MAX)
        else $error("direct output not saturated");
endmodule

`default_nettype wire

// ==== verilog/lszm_pkg.sv ====
// Package: constants, field layouts and types for the sensor result stage
package lszm_pkg;
    // ------------------------------------------------------------
    // Bus carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;               // Slave selected
        logic        penable;            // Access phase
        logic        pwrite;             // Write when high
        logic [7:0]  paddr;              // Byte address
        logic [31:0] pwdata;             // Write data
    } lszm_apb_req_t;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;  // Mode control
    localparam logic [7:0] OFF_OUTWORD = 8'h04;  // Controller output word
    localparam logic [7:0] OFF_INWORD  = 8'h08;  // Input word (read only)
    localparam logic [7:0] OFF_STATUS  = 8'h0C;  // Unit status (read only)
    localparam logic [7:0] OFF_HYST    = 8'h10;  // Hysteresis width
    localparam logic [7:0] OFF_SP_XT   = 8'h14;  // Extreme top setpoint
    localparam logic [7:0] OFF_SP_T    = 8'h18;  // Top setpoint
    localparam logic [7:0] OFF_SP_B    = 8'h1C;  // Bottom setpoint
    localparam logic [7:0] OFF_SP_DB   = 8'h20;  // Deep bottom setpoint
    localparam logic [7:0] OFF_X1      = 8'h24;  // First scaling point
    localparam logic [7:0] OFF_X2      = 8'h28;  // Second scaling point
    localparam logic [7:0] OFF_ZOFS    = 8'h2C;  // Zero shift (read only)

    // ------------------------------------------------------------
    // Control fields and codes
    // ------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;            // 1 = comparison mode
    localparam int CTRL_HOLD_LSB = 1;            // Hold type, 3 bits
    localparam int CTRL_MON_BIT  = 4;            // 1 = direct output
    localparam int CTRL_TYPE_LSB = 5;            // Input type, 2 bits
    localparam logic [2:0] HOLD_NORMAL = 3'h0;
    localparam logic [2:0] HOLD_SAMPLE = 3'h1;
    localparam logic [2:0] HOLD_MAX    = 3'h2;
    localparam logic [2:0] HOLD_MIN    = 3'h3;
    localparam logic [2:0] HOLD_P2P    = 3'h4;
    localparam logic [1:0] TYPE_1TO5V  = 2'h2;   // Unipolar types start here
    localparam logic [6:0] CTRL_RST    = 7'h00;

    // Input word flag positions in comparison mode
    localparam int FLG_DB = 0;
    localparam int FLG_B  = 1;
    localparam int FLG_IN = 2;
    localparam int FLG_T  = 3;
    localparam int FLG_XT = 4;
    localparam int FLG_OV = 5;

    // Command decode in the output word
    localparam logic [3:0]  CMD_NIB       = 4'hC;
    localparam logic [3:0]  CMD_SCL_TEACH = 4'h5;
    localparam logic [3:0]  CMD_SET_TEACH = 4'h8;
    localparam logic [15:0] WORD_INVALID  = 16'hBBBB;  // No data held

    // Value limits and reset values
    localparam logic signed [15:0] VAL_MAX   = 16'sh270F;  // +9999
    localparam logic signed [15:0] VAL_MIN   = 16'shD8F1;  // -9999
    localparam logic [15:0]        HYST_RST  = 16'h0000;
    localparam logic [15:0]        ZERO_RST  = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  CLK_HZ       = 20_000_000;
    localparam real MON_PERIOD_S = 0.5;
    localparam int  MON_PERIOD_CYC = int'(MON_PERIOD_S * CLK_HZ);

    // Hold sequencer states
    typedef enum logic [1:0] {HS_EMPTY, HS_GATHER, HS_HELD} lszm_hold_t;

    // Saturate a wide signed value to the displayable range
    function automatic logic signed [15:0] lszm_clamp(
        input logic signed [17:0] v);
        if (v > 18'(VAL_MAX))
            return VAL_MAX;
        else if (v < 18'(VAL_MIN))
            return VAL_MIN;
        else
            return v[15:0];
    endfunction
endpackage

// ==== test/lszm_cpu.sv ====
// Controller model: APB master that moves one word per transfer
`timescale 1ns/100ps
`default_nettype none
module lszm_cpu (
    input  wire logic                    clk,
    input  wire logic                    pready,
    output var  lszm_pkg::lszm_apb_req_t req
);
    import lszm_pkg::*;
    initial req = '0;
    // ------------------------------------------------------------
    // Transfer: setup cycle, then access until pready is seen
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        req <= '0;  // Released only after the sampled answer
    endtask
endmodule
`default_nettype wire

// ==== test/tb_linear_sensor_compare_zero_monitor.sv ====
// Self-checking bench for the sensor result stage
`timescale 1ns/100ps
`default_nettype none
module tb_linear_sensor_compare_zero_monitor;
    import lszm_pkg::*;
    logic clk = 0, rst = 1, nreq = 0, ncan = 0, ov = 0, gt = 0, rl = 0;
    logic pready, pslverr, zlamp, olamp, glamp;
    logic signed [15:0] sval = '0, mon;
    logic [15:0] raw = '0;
    logic [31:0] prdata, seed = 32'h0000_001F;
    logic [15:0] tv[4] = '{16'h270F, 16'h270B, 16'h0000, 16'hD8F1};
    logic [31:0] fl[4] = '{32'h18, 32'h18, 32'h04, 32'h03};
    lszm_apb_req_t req;
    logic [31:0] q[$];  // Expected read data, oldest first
    int err_count = 0, checks = 0;
    lszm_top #(.MON_CYC(20)) dut (.CLK(clk), .RST(rst), .APB_REQ(req),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SCALED_VALUE(sval), .RAW_VALUE(raw), .OVERRANGE(ov),
        .OPEN_DETECT(ov), .SAMPLE_GATE_INPUT(gt),
        .HOLD_RELEASE_INPUT(rl), .NULL_REQUEST_INPUT(nreq),
        .NULL_CANCEL_INPUT(ncan), .MON_CODE(mon), .ZERO_LAMP(zlamp),
        .OPEN_INPUT_LAMP(olamp), .GATE_LAMP(glamp));
    lszm_cpu u_cpu (.clk(clk), .pready(pready), .req(req));
    always #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_cpu.xfer(1'b1, a, {16'h0000, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        u_cpu.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic results;
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watcher: each completed read retires the oldest note
    always @(posedge clk)
        if (req.psel && req.penable && pready) begin
            cmp({31'h0, pslverr}, {31'h0, req.paddr > OFF_ZOFS});
            if (!req.pwrite)
                cmp(prdata, q.pop_front());
        end
    // Watchdog: far beyond the few hundred cycles the run needs
    initial begin
        #200_000;
        err_count++;
        results;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_SP_XT, 32'h0000_270F);
        rd(8'h30, 32'h0000_0000);      // Unmapped place reads zero
        seed = xs(seed);
        raw <= seed[15:0];
        wr(OFF_OUTWORD, 16'hC500);
        rd(OFF_X1, {16'h0000, raw});
        wr(OFF_CTRL, 16'h0002);        // Sampling hold refuses teach
        wr(OFF_OUTWORD, 16'hC510);
        rd(OFF_STATUS, 32'h0000_0001);
        rd(OFF_INWORD, 32'h0000_BBBB);
        gt <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFF_INWORD, 32'h0000_0000);
        cmp({31'h0, glamp}, 32'h1);
        {gt, rl} <= 2'b01;
        repeat (6) @(posedge clk);
        rl <= 1'b0;
        rd(OFF_INWORD, 32'h0000_BBBB);
        wr(OFF_CTRL, 16'h0001);
        wr(OFF_HYST, 16'h000A);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            sval <= (i == 2) ? {{4{seed[11]}}, seed[11:0]} : tv[i];
            repeat (3) @(posedge clk);
            rd(OFF_INWORD, fl[i]);
        end
        ov <= 1'b1;
        rd(OFF_INWORD, 32'h0000_0023);
        cmp({31'h0, olamp}, 32'h0);
        wr(OFF_CTRL, 16'h0041);
        @(posedge clk);
        cmp({31'h0, olamp}, 32'h1);
        ov <= 1'b0;
        wr(OFF_CTRL, 16'h0000);
        nreq <= 1'b1;
        repeat (8) @(posedge clk);
        nreq <= 1'b0;
        rd(OFF_INWORD, 32'h0000_0000);
        cmp({31'h0, zlamp}, 32'h1);
        ncan <= 1'b1;
        repeat (8) @(posedge clk);
        ncan <= 1'b0;
        cmp({31'h0, zlamp}, 32'h0);
        rd(OFF_INWORD, {16'h0000, sval});
        repeat (30) @(posedge clk);
        cmp({16'h0000, mon}, {16'h0000, sval});
        wr(OFF_CTRL, 16'h0008);        // Peak-to-peak hold
        nreq <= 1'b1;
        repeat (8) @(posedge clk);
        nreq <= 1'b0;
        cmp({31'h0, zlamp}, 32'h0);
        wr(OFF_CTRL, 16'h0010);
        wr(OFF_OUTWORD, 16'hD8F0);
        wr(OFF_OUTWORD, 16'hC000);
        rd(OFF_OUTWORD, 32'h0000_D8F0);
        repeat (30) @(posedge clk);
        cmp({16'h0000, mon}, 32'h0000_D8F1);
        wr(OFF_OUTWORD, 16'h1234);
        repeat (30) @(posedge clk);
        cmp({16'h0000, mon}, 32'h0000_1234);
        results;
    end
endmodule
`default_nettype wire
